// ===== core/pin_mux_consts.svh
// Pin mux constants: widths, strap positions, reset values.
// Assumes inclusion by bare name from package and modules.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define ADDR_W 14
`define DATA_W 24
`define UPPER_LSB 8
`define HOST_W 16
`define FLAG_W 8
`define STRAP_A 0
`define STRAP_B 1
`define STRAP_C 2
`define STRAP_WAIT 2'h3
`define MODE_FULL 1'b0
`define MODE_HOST 1'b1
`define SEL_IDLE 5'h1f
`endif

// ===== core/pin_mux_pkg.sv
// Types shared by both ends of the pin mux.
// Assumes pin_mux_consts.svh on the include path.
`include "pin_mux_consts.svh"
package pin_mux_pkg;
  typedef enum logic {mem_full = `MODE_FULL, mem_host = `MODE_HOST} mem_mode_e;
  typedef enum logic [1:0] {
    bus_own = 2'b00,
    bus_granted = 2'b01,
    bus_hung = 2'b11
  } bus_state_e;
  // Select strobes, active low: data, program, io, byte, combined
  typedef struct packed {
    logic data_sel_n;
    logic prog_sel_n;
    logic io_sel_n;
    logic byte_sel_n;
    logic comb_sel_n;
  } sel_t;
endpackage : pin_mux_pkg

// ===== core/pin_mux_if.sv
// Pin-level link between the processor pin mux and the outside party.
// Assumes the outside end resolves two-way wires from the enables.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
interface pin_mux_if;
  logic reset_n;
  logic [`FLAG_W-1:0] flag_o;
  logic [`FLAG_W-1:0] flag_oe;
  logic [`FLAG_W-1:0] flag_i;
  logic [`ADDR_W-1:0] ext_addr_bus;
  logic [`DATA_W-1:0] ext_data_o;
  logic [`DATA_W-1:0] ext_data_oe;
  logic [`DATA_W-1:0] ext_data_i;
  logic [`HOST_W-1:0] host_ad_o;
  logic [`HOST_W-1:0] host_ad_oe;
  logic [`HOST_W-1:0] host_ad_i;
  logic host_write_enable_n;
  logic host_read_enable_n;
  logic host_addr_latch;
  logic host_port_select_n;
  logic host_port_ack_n;
  pin_mux_pkg::sel_t sel;
  logic read_en_n;
  logic write_en_n;
  logic bus_request_in_n;
  logic bus_grant_out_n;
  logic bus_grant_hung_out_n;
  logic [1:0] serial_alt_irqs_n;
  logic serial_alt_flag_in;
  logic serial_alt_flag_out;
  modport device (
    input reset_n, flag_i, ext_data_i, host_ad_i, host_write_enable_n,
    host_read_enable_n, host_addr_latch, host_port_select_n,
    bus_request_in_n, serial_alt_irqs_n, serial_alt_flag_in,
    output flag_o, flag_oe, ext_addr_bus, ext_data_o, ext_data_oe,
    host_ad_o, host_ad_oe, host_port_ack_n, sel, read_en_n, write_en_n,
    bus_grant_out_n, bus_grant_hung_out_n, serial_alt_flag_out
  );
  modport host (
    output reset_n, flag_i, ext_data_i, host_ad_i, host_write_enable_n,
    host_read_enable_n, host_addr_latch, host_port_select_n,
    bus_request_in_n, serial_alt_irqs_n, serial_alt_flag_in,
    input flag_o, flag_oe, ext_addr_bus, ext_data_o, ext_data_oe,
    host_ad_o, host_ad_oe, host_port_ack_n, sel, read_en_n, write_en_n,
    bus_grant_out_n, bus_grant_hung_out_n, serial_alt_flag_out
  );
endinterface : pin_mux_if

// ===== core/memory_mode_pin_mux.sv
// Device end: strap capture, bus pin mux, flag/irq sharing, bus grant.
// Assumes core-side requests are on mclk; pins on the link are async.
//
// Contract
// - Bus pin configuration fixed only during reset
// - Serial pin function switchable any time
// - Shared flag/irq pins keep both functions
// - Memory mode from strap, held while running
// - Strap low full mode, high host
// - Straps read in reset, then flags; the device takes them on the third edge after release
// - Full mode: 14 address, 24 data bits
// - Host mode: 16-bit muxed address/data port
// - Host mode: lowest address, upper data only
// - Host drives port strobes, device acknowledges
// - Alternate serial pins: two irqs, flags (the flag input is synchronised but never reaches the core)
// - Host decodes peripherals from A0, strobes
// - Separate low select strobes plus combined
// - Bus request answered by grant, hung grant
// - Strap driver active only during reset
// - Three irqs programmable edge or level
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module memory_mode_pin_mux (
  input wire logic mclk,
  pin_mux_if.device pins,
  input wire logic core_serial_alt,
  input wire logic [`FLAG_W-1:0] core_flag_out,
  input wire logic [`FLAG_W-1:0] core_flag_dir,
  output logic [`FLAG_W-1:0] core_flag_in,
  input wire logic [2:0] core_irq_edge,
  output logic [5:0] core_irq_req,
  input wire logic [2:0] core_irq_clr,
  input wire logic core_serial_fo,
  input wire logic [`ADDR_W-1:0] core_addr,
  input wire logic [`DATA_W-1:0] core_wdata,
  input wire logic core_write,
  output logic [`DATA_W-1:0] core_rdata,
  input wire logic [4:0] core_space_n,
  input wire logic core_rd_n,
  input wire logic core_wr_n,
  input wire logic core_bus_stall,
  input wire logic core_host_ack,
  output logic [`HOST_W-1:0] host_addr,
  output logic host_addr_valid,
  output logic [`HOST_W-1:0] host_wdata,
  output logic host_wr_strobe,
  output logic host_rd_strobe,
  input wire logic [`HOST_W-1:0] host_rdata,
  output logic [2:0] mode_straps,
  output pin_mux_pkg::mem_mode_e mem_mode
);
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [1:0] strap_wait;
    logic [2:0] straps;
    logic [`FLAG_W-1:0] flag_s1;
    logic [`FLAG_W-1:0] flag_s2;
    logic [`FLAG_W-1:0] flag_p;
    logic [`DATA_W-1:0] dat_s1;
    logic [`DATA_W-1:0] dat_s2;
    logic [`HOST_W-1:0] iad_s1;
    logic [`HOST_W-1:0] iad_s2;
    logic [3:0] hctl_s1;
    logic [3:0] hctl_s2;
    logic [3:0] hctl_p;
    logic [1:0] sirq_s1;
    logic [1:0] sirq_s2;
    logic [1:0] sirq_p;
    logic sfi_s1;
    logic sfi_s2;
    logic br_s1;
    logic br_s2;
    logic [2:0] edge_hit;
    logic edge_irq_in_hit;
    pin_mux_pkg::bus_state_e bus;
    logic [`HOST_W-1:0] haddr;
    logic haddr_v;
    logic [`HOST_W-1:0] hwdata;
    logic hwr;
    logic hrd;
    logic [`HOST_W-1:0] hrdata;
    logic hdrive;
    logic ack_n;
  } state_s;
  state_s s_q;
  state_s s_d;
  logic host_m;
  logic granted;
  logic [2:0] lvl_src;
  logic [2:0] edge_in;
  logic [3:0] hc;
  logic reset_n_i;
  assign host_m = s_q.straps[`STRAP_C];
  assign granted = (s_q.bus != pin_mux_pkg::bus_own);
  assign hc = s_q.hctl_s2; // {sel_n, al, rd_n, wr_n}
  // General irq on flag 7, alternate serial irqs on serial pins
  assign lvl_src = {~s_q.flag_s2[7], ~s_q.sirq_s2};
  assign edge_in = lvl_src & ~{~s_q.flag_p[7], ~s_q.sirq_p};
  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    s_d = s_q;
    s_d.flag_s1 = pins.flag_i;
    s_d.flag_s2 = s_q.flag_s1;
    s_d.flag_p = s_q.flag_s2;
    s_d.dat_s1 = pins.ext_data_i;
    s_d.dat_s2 = s_q.dat_s1;
    s_d.iad_s1 = pins.host_ad_i;
    s_d.iad_s2 = s_q.iad_s1;
    s_d.hctl_s1 = {pins.host_port_select_n, pins.host_addr_latch,
                   pins.host_read_enable_n, pins.host_write_enable_n};
    s_d.hctl_s2 = s_q.hctl_s1;
    s_d.hctl_p = s_q.hctl_s2;
    s_d.sirq_s1 = pins.serial_alt_irqs_n;
    s_d.sirq_s2 = s_q.sirq_s1;
    s_d.sirq_p = s_q.sirq_s2;
    s_d.sfi_s1 = pins.serial_alt_flag_in;
    s_d.sfi_s2 = s_q.sfi_s1;
    s_d.br_s1 = pins.bus_request_in_n;
    s_d.br_s2 = s_q.br_s1;
    // Straps taken on the third edge after release: the synchroniser
    // is held in reset, so only then does its second stage show the pin
    if (s_q.strap_wait != 2'h0) begin
      s_d.strap_wait = s_q.strap_wait - 2'h1;
      if (s_q.strap_wait == 2'h1) begin
        s_d.straps = s_q.flag_s2[2:0];
      end
    end
    // Set wins over clear for latched edges
    s_d.edge_hit = (s_q.edge_hit & ~core_irq_clr)
      | (edge_in & core_irq_edge);
    // Falling edge on flag 4 latches until the pin goes high again
    s_d.edge_irq_in_hit = s_q.flag_s2[4] ? 1'b0
      : (s_q.edge_irq_in_hit | s_q.flag_p[4]);
    // Bus arbitration: grant when core idle, hung if core stalls
    unique case (s_q.bus)
      pin_mux_pkg::bus_own: begin
        if (!s_q.br_s2 && !core_bus_stall)
          s_d.bus = pin_mux_pkg::bus_granted;
      end
      pin_mux_pkg::bus_granted: begin
        if (s_q.br_s2)
          s_d.bus = pin_mux_pkg::bus_own;
        else if (core_bus_stall)
          s_d.bus = pin_mux_pkg::bus_hung;
      end
      pin_mux_pkg::bus_hung: begin
        if (s_q.br_s2)
          s_d.bus = pin_mux_pkg::bus_own;
        else if (!core_bus_stall)
          s_d.bus = pin_mux_pkg::bus_granted;
      end
      default: s_d.bus = pin_mux_pkg::bus_own;
    endcase
    // Host port: one-cycle strobes on the synchronised address-latch rising edge and enable falling edges
    s_d.haddr_v = 1'b0;
    s_d.hwr = 1'b0;
    s_d.hrd = 1'b0;
    if (host_m && !hc[3]) begin
      if (hc[2] && !s_q.hctl_p[2]) begin
        s_d.haddr = s_q.iad_s2;
        s_d.haddr_v = 1'b1;
      end
      if (!hc[0] && s_q.hctl_p[0]) begin
        s_d.hwdata = s_q.iad_s2;
        s_d.hwr = 1'b1;
      end
      if (!hc[1] && s_q.hctl_p[1])
        s_d.hrd = 1'b1;
    end
    if (s_q.hrd)
      s_d.hrdata = host_rdata;
    s_d.hdrive = host_m && !hc[3] && !hc[1];
    s_d.ack_n = ~(host_m && core_host_ack);
  end
  always_ff @(posedge mclk or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.strap_wait <= `STRAP_WAIT;
      s_q.flag_s1 <= '1;
      s_q.flag_s2 <= '1;
      s_q.flag_p <= '1;
      s_q.hctl_s1 <= 4'hf;
      s_q.hctl_s2 <= 4'hf;
      s_q.hctl_p <= 4'hf;
      s_q.sirq_s1 <= 2'h3;
      s_q.sirq_s2 <= 2'h3;
      s_q.sirq_p <= 2'h3;
      s_q.br_s1 <= 1'b1;
      s_q.br_s2 <= 1'b1;
      s_q.ack_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // ********************************************************
  // Pins
  // ********************************************************
  always_comb begin
    reset_n_i = pins.reset_n;
  end
  // Flags stay inputs while the straps are being read
  assign pins.flag_o = core_flag_out;
  assign pins.flag_oe = (s_q.strap_wait != 2'h0) ? '0
    : core_flag_dir;
  assign core_flag_in = s_q.flag_s2;
  // Interrupts: general; level a/b; edge on flag 4; serial a/b by mode
  assign core_irq_req = {
    core_irq_edge[2] ? s_q.edge_hit[2] : lvl_src[2],
    ~s_q.flag_s2[5], ~s_q.flag_s2[6], s_q.edge_irq_in_hit,
    core_serial_alt & (core_irq_edge[1] ? s_q.edge_hit[1] : lvl_src[1]),
    core_serial_alt & (core_irq_edge[0] ? s_q.edge_hit[0] : lvl_src[0])
  };
  assign pins.serial_alt_flag_out = core_serial_alt & core_serial_fo;
  // External bus: full width in full mode, A0 and upper byte lanes in host
  assign pins.ext_addr_bus = granted ? '0 : (host_m ?
    {{(`ADDR_W-1){1'b0}}, core_addr[0]} : core_addr);
  assign pins.ext_data_o = core_wdata;
  assign pins.ext_data_oe = (granted || !core_write) ? '0 : (host_m ?
    {{(`HOST_W){1'b1}}, {`UPPER_LSB{1'b0}}} : '1);
  assign core_rdata = host_m ?
    {s_q.dat_s2[`DATA_W-1:`UPPER_LSB], {`UPPER_LSB{1'b0}}} : s_q.dat_s2;
  assign pins.sel = granted ? `SEL_IDLE : core_space_n;
  assign pins.read_en_n = granted | core_rd_n;
  assign pins.write_en_n = granted | core_wr_n;
  assign pins.bus_grant_out_n = ~granted;
  assign pins.bus_grant_hung_out_n = (s_q.bus != pin_mux_pkg::bus_hung);
  assign pins.host_ad_o = s_q.hrdata;
  assign pins.host_ad_oe = {`HOST_W{s_q.hdrive}};
  assign pins.host_port_ack_n = s_q.ack_n;
  assign host_addr = s_q.haddr;
  assign host_addr_valid = s_q.haddr_v;
  assign host_wdata = s_q.hwdata;
  assign host_wr_strobe = s_q.hwr;
  assign host_rd_strobe = s_q.hrd;
  assign mode_straps = s_q.straps;
  assign mem_mode = pin_mux_pkg::mem_mode_e'(s_q.straps[`STRAP_C]);
endmodule : memory_mode_pin_mux

// ===== core/pin_mux_host_end.sv
// Outside end: drives reset, straps, host port strobes and bus request.
// Assumes the user side gives requests on mclk; device pins are async.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module pin_mux_host_end (
  input wire logic mclk,
  input wire logic reset_n,
  pin_mux_if.host pins,
  input wire logic [2:0] strap_level,
  input wire logic [`FLAG_W-1:0] flag_drive,
  input wire logic [`FLAG_W-1:0] flag_drive_en,
  input wire logic [`DATA_W-1:0] mem_rdata,
  input wire logic [1:0] serial_irq_n,
  input wire logic serial_flag,
  input wire logic bus_req,
  output logic bus_granted,
  output logic bus_hung,
  input wire logic host_start,
  input wire logic host_is_write,
  input wire logic [`HOST_W-1:0] host_addr,
  input wire logic [`HOST_W-1:0] host_wdata,
  output logic host_busy,
  output logic [`HOST_W-1:0] host_rdata,
  output logic host_acked,
  output logic [3:0] periph_sel
);
  typedef enum logic [2:0] {
    h_idle = 3'b000, h_latch = 3'b001, h_gap = 3'b011,
    h_strobe = 3'b010, h_done = 3'b110
  } host_e;
  typedef struct packed {
    host_e st;
    logic wr;
    logic [`HOST_W-1:0] wd;
    logic [`HOST_W-1:0] rd;
    logic [2:0] cnt;
    logic ack_s1;
    logic ack_s2;
    logic [1:0] bg_s1;
    logic [1:0] bg_s2;
  } state_s;
  state_s s_q;
  state_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.ack_s1 = pins.host_port_ack_n;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.bg_s1 = {pins.bus_grant_hung_out_n, pins.bus_grant_out_n};
    s_d.bg_s2 = s_q.bg_s1;
    unique case (s_q.st)
      h_idle: begin
        if (host_start) begin
          s_d.st = h_latch;
          s_d.wr = host_is_write;
          s_d.wd = host_wdata;
          s_d.cnt = 3'h4;
        end
      end
      h_latch: begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1) begin
          s_d.st = h_gap;
          s_d.cnt = 3'h4;
        end
      end
      h_gap: begin
        s_d.st = h_strobe;
        s_d.cnt = 3'h7;
      end
      h_strobe: begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1) begin
          s_d.st = h_done;
          s_d.rd = pins.host_ad_i;
        end
      end
      h_done: s_d.st = h_idle;
      default: s_d.st = h_idle;
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ack_s1 <= 1'b1;
      s_q.ack_s2 <= 1'b1;
      s_q.bg_s1 <= 2'h3;
      s_q.bg_s2 <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end
  assign pins.reset_n = reset_n;
  // Device wins where it drives, else the outside, else the pull-ups;
  // the strap driver overrides flags 2:0 only while reset is low
  always_comb begin
    pins.flag_i = (pins.flag_oe & pins.flag_o)
      | (~pins.flag_oe & (~flag_drive_en | flag_drive));
    if (!reset_n) begin
      pins.flag_i[2:0] = strap_level;
    end
  end
  assign pins.ext_data_i = mem_rdata;
  assign pins.serial_alt_irqs_n = serial_irq_n;
  assign pins.serial_alt_flag_in = serial_flag;
  assign pins.bus_request_in_n = ~bus_req;
  assign pins.host_port_select_n = (s_q.st == h_idle);
  assign pins.host_addr_latch = (s_q.st == h_latch);
  assign pins.host_write_enable_n = ~((s_q.st == h_strobe) && s_q.wr);
  assign pins.host_read_enable_n = ~((s_q.st == h_strobe) && !s_q.wr);
  // Released bus shows the device's drive, else reads high
  logic host_oe;
  assign host_oe = (s_q.st == h_latch) || (s_q.st == h_strobe && s_q.wr);
  assign pins.host_ad_i = host_oe ?
    ((s_q.st == h_latch) ? host_addr : s_q.wd)
    : ((pins.host_ad_oe & pins.host_ad_o) | ~pins.host_ad_oe);
  assign host_busy = (s_q.st != h_idle);
  assign host_rdata = s_q.rd;
  assign host_acked = ~s_q.ack_s2;
  assign bus_granted = ~s_q.bg_s2[0];
  assign bus_hung = ~s_q.bg_s2[1];
  // Peripheral decode from A0 and space strobes
  // I/O split by A0; memory spaces qualified by the combined strobe
  assign periph_sel = {
    ~pins.sel.io_sel_n & pins.ext_addr_bus[0],
    ~pins.sel.io_sel_n & ~pins.ext_addr_bus[0],
    ~pins.sel.data_sel_n & ~pins.sel.comb_sel_n,
    ~pins.sel.prog_sel_n & ~pins.sel.comb_sel_n};
endmodule : pin_mux_host_end

// ===== verif/memory_mode_pin_mux_chk.sv
// Checker of pin-level relations between the two pin mux ends.
// Assumes instantiation beside the interface, every signal by name.
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module memory_mode_pin_mux_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`FLAG_W-1:0] flag_i,
  input wire logic [`FLAG_W-1:0] flag_oe,
  input wire logic [`DATA_W-1:0] ext_data_oe,
  input wire logic [`HOST_W-1:0] host_ad_oe,
  input wire logic host_port_ack_n,
  input wire pin_mux_pkg::sel_t sel,
  input wire logic read_en_n,
  input wire logic write_en_n,
  input wire logic bus_request_in_n,
  input wire logic bus_grant_out_n,
  input wire logic bus_grant_hung_out_n
);
  // ****************************************
  // Strap seen on the wire
  // ****************************************
  // Only tracked in reset; while running the pin is a plain flag
  logic mode_q;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_q <= flag_i[`STRAP_C];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_strap_no_drive: assert property (
    $rose(reset_n) |-> flag_oe == '0)
    else $error("flag driven in strap cycle");
  a_idle_at_release: assert property (
    $rose(reset_n) |-> sel == `SEL_IDLE && read_en_n && write_en_n)
    else $error("strobes not idle after reset");
  a_rd_wr_apart: assert property (
    !(!read_en_n && !write_en_n))
    else $error("read and write enables low together");
  a_grant_answers: assert property (
    $fell(bus_request_in_n) |-> ##[1:8] !bus_grant_out_n)
    else $error("bus request not granted");
  a_grant_needs_req: assert property (
    $fell(bus_grant_out_n) |-> $past(!bus_request_in_n, 2))
    else $error("grant without request");
  a_hung_needs_req: assert property (
    $fell(bus_grant_hung_out_n) |-> !bus_request_in_n && !bus_grant_out_n)
    else $error("hung grant without grant");
  a_port_off_full: assert property (
    !mode_q |-> host_ad_oe == '0 && host_port_ack_n)
    else $error("host port active in full mode");
  a_upper_only_host: assert property (
    mode_q |-> ext_data_oe[`UPPER_LSB-1:0] == '0)
    else $error("low data bits driven in host mode");
endmodule : memory_mode_pin_mux_chk

// ===== verif/memory_mode_pin_mux_bench.sv
// Bench joining device end and outside end across the pin interface.
// Assumes the core files compiled first; user sides driven here.
`timescale 1ns/1ps
module memory_mode_pin_mux_bench;
  logic mclk, reset_n;
  logic core_serial_alt, core_serial_fo, core_write, core_rd_n, core_wr_n;
  logic core_bus_stall, core_host_ack, serial_flag, bus_req, bus_granted;
  logic bus_hung, host_start, host_is_write, host_busy, host_acked;
  logic d_addr_valid, d_wr_strobe, d_rd_strobe;
  logic [7:0] core_flag_out, core_flag_dir, core_flag_in;
  logic [7:0] flag_drive, flag_drive_en;
  logic [2:0] core_irq_edge, core_irq_clr, mode_straps, strap_level;
  logic [5:0] core_irq_req;
  logic [13:0] core_addr;
  logic [23:0] core_wdata, core_rdata, mem_rdata;
  logic [4:0] core_space_n;
  logic [15:0] d_addr, d_wdata, d_rdata, h_addr, h_wdata, h_rdata;
  logic [1:0] serial_irq_n;
  logic [3:0] periph_sel;
  pin_mux_pkg::mem_mode_e mem_mode;
  int num_errors, num_checks;
  pin_mux_if pins ();
  memory_mode_pin_mux memory_mode_pin_mux_inst (.mclk(mclk),
    .pins(pins.device), .core_serial_alt(core_serial_alt),
    .core_flag_out(core_flag_out), .core_flag_dir(core_flag_dir),
    .core_flag_in(core_flag_in), .core_irq_edge(core_irq_edge),
    .core_irq_req(core_irq_req), .core_irq_clr(core_irq_clr),
    .core_serial_fo(core_serial_fo), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_write(core_write),
    .core_rdata(core_rdata), .core_space_n(core_space_n),
    .core_rd_n(core_rd_n), .core_wr_n(core_wr_n),
    .core_bus_stall(core_bus_stall), .core_host_ack(core_host_ack),
    .host_addr(d_addr), .host_addr_valid(d_addr_valid),
    .host_wdata(d_wdata), .host_wr_strobe(d_wr_strobe),
    .host_rd_strobe(d_rd_strobe), .host_rdata(d_rdata),
    .mode_straps(mode_straps), .mem_mode(mem_mode));
  pin_mux_host_end pin_mux_host_end_inst (.mclk(mclk), .reset_n(reset_n),
    .pins(pins.host), .strap_level(strap_level), .flag_drive(flag_drive),
    .flag_drive_en(flag_drive_en), .mem_rdata(mem_rdata),
    .serial_irq_n(serial_irq_n), .serial_flag(serial_flag),
    .bus_req(bus_req), .bus_granted(bus_granted), .bus_hung(bus_hung),
    .host_start(host_start), .host_is_write(host_is_write),
    .host_addr(h_addr), .host_wdata(h_wdata), .host_busy(host_busy),
    .host_rdata(h_rdata), .host_acked(host_acked), .periph_sel(periph_sel));
  memory_mode_pin_mux_chk memory_mode_pin_mux_chk_inst (.mclk(mclk),
    .reset_n(pins.reset_n), .flag_i(pins.flag_i), .flag_oe(pins.flag_oe),
    .ext_data_oe(pins.ext_data_oe), .host_ad_oe(pins.host_ad_oe),
    .host_port_ack_n(pins.host_port_ack_n), .sel(pins.sel),
    .read_en_n(pins.read_en_n), .write_en_n(pins.write_en_n),
    .bus_request_in_n(pins.bus_request_in_n),
    .bus_grant_out_n(pins.bus_grant_out_n),
    .bus_grant_hung_out_n(pins.bus_grant_hung_out_n));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [23:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Straps stay on flags 2:0 past release until the device has taken them
  task automatic do_reset(input logic [2:0] strap);
    @(posedge mclk);
    reset_n <= 1'b0;
    strap_level <= strap;
    flag_drive <= {5'h00, strap};
    flag_drive_en <= 8'h07;
    tick(12);
    reset_n <= 1'b1;
    tick(5);
    flag_drive <= {5'h00, ~strap};
    tick(4);
    flag_drive <= 8'hf0;
    flag_drive_en <= 8'hf0;
    @(negedge mclk);
    check("straps", 24'(strap), 24'(mode_straps));
    check("mode", 24'(strap[2]), 24'(mem_mode));
    $display("reset with straps %b done", strap);
  endtask : do_reset
  task automatic test_bus(input logic host);
    logic [23:0] oe;
    oe = host ? 24'hffff00 : 24'hffffff;
    @(posedge mclk);
    {core_addr, core_wdata, core_write, core_wr_n} <=
      {14'h2a5b, 24'hc3a5f0, 2'b10};
    core_space_n <= 5'h0e;
    @(negedge mclk);
    check("addr", host ? 24'h1 : 24'h2a5b,
      24'(pins.ext_addr_bus));
    check("data_oe", oe, pins.ext_data_oe);
    check("wdata", oe & 24'hc3a5f0, pins.ext_data_o & oe);
    check("sel", 24'h0e, 24'(pins.sel));
    check("periph", 24'h2, 24'(periph_sel));
    @(posedge mclk);
    {core_write, core_wr_n, core_rd_n, mem_rdata} <= {3'b010, 24'h7e1d24};
    tick(4);
    @(negedge mclk);
    check("rdata", oe & 24'h7e1d24, core_rdata);
    @(posedge mclk);
    {core_rd_n, core_space_n} <= 6'h3f;
    $display("bus test done");
  endtask : test_bus
  task automatic test_flags_irq;
    @(posedge mclk);
    {core_flag_dir, core_flag_out, flag_drive} <= {16'h0808, 8'hc0};
    tick(4);
    @(negedge mclk);
    check("flag3", 24'h1, 24'(core_flag_in[3]));
    check("flag5", 24'h0, 24'(core_flag_in[5]));
    check("irq_a", 24'h1, 24'(core_irq_req[4]));
    check("irq_e", 24'h1, 24'(core_irq_req[2]));
    @(posedge mclk);
    {core_irq_edge, flag_drive} <= {3'b100, 8'h70};
    @(posedge mclk);
    flag_drive <= 8'hf0;
    tick(5);
    @(negedge mclk);
    check("irq_edge", 24'h1, 24'(core_irq_req[5]));
    check("irq_e_off", 24'h0, 24'(core_irq_req[2]));
    @(posedge mclk);
    core_irq_clr <= 3'b100;
    @(posedge mclk);
    core_irq_clr <= 3'b000;
    tick(3);
    @(negedge mclk);
    check("irq_clr", 24'h0, 24'(core_irq_req[5]));
    $display("flag and irq test done");
  endtask : test_flags_irq
  task automatic test_serial_alt;
    @(posedge mclk);
    {core_serial_alt, serial_irq_n, core_serial_fo} <= 4'b1101;
    tick(5);
    @(negedge mclk);
    check("ser_irq", 24'h1, 24'(core_irq_req[1:0]));
    check("ser_fo", 24'h1, 24'(pins.serial_alt_flag_out));
    @(posedge mclk);
    core_serial_alt <= 1'b0;
    tick(5);
    @(negedge mclk);
    check("ser_off", 24'h0, 24'(core_irq_req[1:0]));
    check("ser_fo_off", 24'h0, 24'(pins.serial_alt_flag_out));
    @(posedge mclk);
    serial_irq_n <= 2'b11;
    $display("serial alternate test done");
  endtask : test_serial_alt
  task automatic test_grant;
    @(posedge mclk);
    bus_req <= 1'b1;
    for (int i = 0; i < 12 && bus_granted !== 1'b1; i++) @(negedge mclk);
    check("granted", 24'h1, 24'(bus_granted));
    @(posedge mclk);
    core_bus_stall <= 1'b1;
    for (int i = 0; i < 12 && bus_hung !== 1'b1; i++) @(negedge mclk);
    check("hung", 24'h1, 24'(bus_hung));
    @(posedge mclk);
    {bus_req, core_bus_stall} <= 2'b00;
    for (int i = 0; i < 12 && bus_granted !== 1'b0; i++) @(negedge mclk);
    check("released", 24'h0, 24'(bus_granted));
    $display("bus grant test done");
  endtask : test_grant
  // One call per direction; ack goes out two cycles after the read or write strobe
  task automatic host_xfer(input logic wr);
    @(posedge mclk);
    {host_start, host_is_write, h_addr, h_wdata} <=
      {1'b1, wr, 32'h1234beef};
    @(posedge mclk);
    host_start <= 1'b0;
    for (int i = 0; i < 40 && d_addr_valid !== 1'b1; i++) @(negedge mclk);
    check("haddr_v", 24'h1, 24'(d_addr_valid));
    check("haddr", 24'h1234, 24'(d_addr));
    for (int i = 0; i < 40 && (wr ? d_wr_strobe : d_rd_strobe) !== 1'b1;
      i++) @(negedge mclk);
    check("hstrobe", 24'h1, 24'(wr ? d_wr_strobe : d_rd_strobe));
    if (wr) check("hwdata", 24'hbeef, 24'(d_wdata));
    @(posedge mclk);
    core_host_ack <= 1'b1;
    @(posedge mclk);
    core_host_ack <= 1'b0;
    for (int i = 0; i < 40 && host_acked !== 1'b1; i++) @(negedge mclk);
    check("hacked", 24'h1, 24'(host_acked));
    for (int i = 0; i < 40 && host_busy !== 1'b0; i++) @(negedge mclk);
    check("hbusy", 24'h0, 24'(host_busy));
    if (!wr) check("hrdata", 24'h5a3c, 24'(h_rdata));
    $display("host port transfer done");
  endtask : host_xfer
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial begin
    reset_n = 1'b0;
    {core_serial_alt, core_serial_fo, core_write, core_bus_stall} = '0;
    {core_host_ack, serial_flag, bus_req, host_start, host_is_write} = '0;
    {core_rd_n, core_wr_n, core_space_n, serial_irq_n} = '1;
    {core_flag_out, core_flag_dir, core_irq_edge, core_irq_clr} = '0;
    {core_addr, core_wdata, mem_rdata, h_addr, h_wdata} = '0;
    {strap_level, flag_drive, flag_drive_en} = '0;
    d_rdata = 16'h5a3c;
    do_reset(3'b011);
    test_bus(1'b0);
    test_flags_irq;
    test_serial_alt;
    test_grant;
    do_reset(3'b101);
    test_bus(1'b1);
    host_xfer(1'b1);
    host_xfer(1'b0);
    complete_run;
  end
endmodule : memory_mode_pin_mux_bench
